/* File: ir_pkg.sv */
// Purpose: shared constants for the initial reset block
// Assumes: pclk at 200 MHz, low-speed oscillator near 32.768 kHz
// Notes:   all timing counts are derived from the printed figures
package ir_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned RST_NOISE_NS    = 100;
  localparam int unsigned RST_NOISE_CYC   =
    (RST_NOISE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned OSC_HZ          = 32768;
  localparam int unsigned TICK_HZ         = 16;
  localparam int unsigned TICK_HALF_RISES = OSC_HZ / TICK_HZ / 2;
  localparam int unsigned KEY_HOLD_US     = 1500;
  localparam int unsigned KEY_NR_TICKS    =
    (KEY_HOLD_US * OSC_HZ) / 1000000;
  localparam int unsigned AUTH_MIN_S      = 1;
  localparam int unsigned AUTH_TICKS      = AUTH_MIN_S * TICK_HZ;

  ////////////////////////////////////////////////////////////////////////////
  // cpu reset state
  localparam logic [15:0] START_PC        = 16'h0110;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam logic [7:0] OFS_PORT_DIR     = 8'h00;
  localparam logic [7:0] OFS_STATUS       = 8'h04;
  localparam logic [7:0] OFS_START_PC     = 8'h08;

  // status fields
  localparam int unsigned ST_INIT_RST     = 0;
  localparam int unsigned ST_WIDE_SET     = 1;
  localparam int unsigned ST_NIB_SET      = 2;
  localparam int unsigned ST_INT_OPEN     = 3;
  localparam int unsigned ST_EXT_FLAG     = 4;
  localparam int unsigned ST_INT_FLAG     = 5;
  localparam int unsigned ST_CAUSE_PIN    = 6;
  localparam int unsigned ST_CAUSE_KEY    = 7;

  // key combination mask options
  localparam logic [2:0] KEY_OPT_NONE     = 3'h1;
  localparam logic [2:0] KEY_OPT_TWO      = 3'h2;
  localparam logic [2:0] KEY_OPT_THREE    = 3'h3;
  localparam logic [2:0] KEY_OPT_FOUR     = 3'h4;

  typedef enum logic [3:0] {
    KEY_IDLE   = 4'h1,
    KEY_FILTER = 4'h2,
    KEY_AUTH   = 4'h4,
    KEY_FIRE   = 4'h8
  } ir_key_state_e;

endpackage

/* File: ir_tb_if.sv */
// Purpose: timebase signals between the divider and the reset core
// Assumes: single pclk domain
// Notes:   all signals are one-clock pulses except tick16_hi
`timescale 1ns/1ps
interface ir_tb_if;
  logic osc_rise;
  logic tick16_hi;
  logic tick16_rise;

  modport src
  (
    output osc_rise,
    output tick16_hi,
    output tick16_rise
  );
  modport dst
  (
    input  osc_rise,
    input  tick16_hi,
    input  tick16_rise
  );
endinterface

/* File: ir_timebase.sv */
// Purpose: divides the low-speed oscillator into a 16 Hz square tick
// Assumes: oscillator input already synchronous to pclk
// Notes:   the tick stands high for half of each 16 Hz period
`timescale 1ns/1ps
module ir_timebase
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic low_speed_oscillator,
  ir_tb_if.src      tb
);

  logic        osc_prev_reg;
  logic [10:0] div_reg;
  logic        tick_reg;
  logic        rise_reg;
  logic        tick_rise_reg;

  ////////////////////////////////////////////////////////////////////////////
  // oscillator edge detect
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_prev_reg <= 1'b0;
      rise_reg     <= 1'b0;
    end
    else
    begin
      osc_prev_reg <= low_speed_oscillator;
      rise_reg     <= low_speed_oscillator & ~osc_prev_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // half-period counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_reg       <= 11'h000;
      tick_reg      <= 1'b0;
      tick_rise_reg <= 1'b0;
    end
    else
    begin
      tick_rise_reg <= 1'b0;
      if (rise_reg)
      begin
        if (div_reg == 11'(ir_pkg::TICK_HALF_RISES - 1))
        begin
          div_reg       <= 11'h000;
          tick_reg      <= ~tick_reg;
          tick_rise_reg <= ~tick_reg;
        end
        else
        begin
          div_reg <= div_reg + 11'h001;
        end
      end
    end
  end

  assign tb.osc_rise    = rise_reg;
  assign tb.tick16_hi   = tick_reg;
  assign tb.tick16_rise = tick_rise_reg;

endmodule

/* File: ir_init_reset.sv */
// Purpose: initial reset sequencer with cpu reset state and pin defaults
// Assumes: pins and oscillator synchronous to pclk; APB slave, one wait
// Notes:   mask options are parameters; cpu hooks are pulse inputs
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps

module ir_init_reset
#(
  parameter logic [2:0]  KEY_COMBO     = 3'h1,
  parameter bit          AUTH_EN       = 1'b0,
  parameter bit          RST_PULLDOWN  = 1'b1,
  parameter int unsigned NPORT         = 24,
  parameter logic [23:0] PORT_PULLDOWN = 24'hFFFFFF
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              reset_pin,
  input  wire logic [3:0]        key_input_ports,
  input  wire logic              low_speed_oscillator,
  input  wire logic              wide_stack_pointer_wr,
  input  wire logic              nibble_stack_pointer_wr,
  input  wire logic              extension_register_wr,
  input  wire logic              instr_done,
  input  wire logic              int_flag_wr,
  input  wire logic              int_flag_val,
  output logic                   init_reset,
  output logic [15:0]            program_counter_start,
  output logic                   int_flag,
  output logic                   ext_flag,
  output logic                   int_open,
  output logic                   reset_pin_pulldown_en,
  output logic [NPORT-1:0]       port_oe,
  output logic [NPORT-1:0]       port_pulldown_en
);

  if (KEY_COMBO < ir_pkg::KEY_OPT_NONE || KEY_COMBO > ir_pkg::KEY_OPT_FOUR)
  begin : g_bad_opt
    $error("key combination option must be 1 to 4");
  end
  if (NPORT < 1 || NPORT > 24)
  begin : g_bad_port
    $error("port count must be 1 to 24");
  end

  function automatic logic [3:0] key_mask(input logic [2:0] opt);
    case (opt)
      ir_pkg::KEY_OPT_TWO:   key_mask = 4'h3;
      ir_pkg::KEY_OPT_THREE: key_mask = 4'h7;
      ir_pkg::KEY_OPT_FOUR:  key_mask = 4'hF;
      default:               key_mask = 4'h0;
    endcase
  endfunction

  localparam logic [3:0] KMASK = key_mask(KEY_COMBO);

  ir_tb_if tb ();

  ir_timebase u_timebase
  (
    .pclk                 (pclk),
    .presetn              (presetn),
    .low_speed_oscillator (low_speed_oscillator),
    .tb                   (tb.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // reset pin noise rejecter
  logic [4:0]  pin_cnt_reg;
  logic        pin_qual_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_cnt_reg  <= 5'h00;
      pin_qual_reg <= 1'b0;
    end
    else if (!reset_pin)
    begin
      pin_cnt_reg  <= 5'h00;
      pin_qual_reg <= 1'b0;
    end
    else if (pin_cnt_reg == 5'(ir_pkg::RST_NOISE_CYC - 1))
    begin
      pin_qual_reg <= 1'b1;
    end
    else
    begin
      pin_cnt_reg <= pin_cnt_reg + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // key combination path
  ir_pkg::ir_key_state_e key_state_reg;
  logic [5:0]            key_cnt_reg;
  logic                  key_fire_reg;
  logic                  key_hit;

  assign key_hit = (KMASK != 4'h0) &&
                   ((key_input_ports & KMASK) == KMASK);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      key_state_reg <= ir_pkg::KEY_IDLE;
      key_cnt_reg   <= 6'h00;
      key_fire_reg  <= 1'b0;
    end
    else if (!key_hit)
    begin
      key_state_reg <= ir_pkg::KEY_IDLE;
      key_cnt_reg   <= 6'h00;
      key_fire_reg  <= 1'b0;
    end
    else
    begin
      case (key_state_reg)
        ir_pkg::KEY_IDLE:
        begin
          key_state_reg <= ir_pkg::KEY_FILTER;
          key_cnt_reg   <= 6'h00;
        end
        ir_pkg::KEY_FILTER:
        begin
          if (tb.osc_rise)
          begin
            if (key_cnt_reg == 6'(ir_pkg::KEY_NR_TICKS - 1))
            begin
              key_cnt_reg   <= 6'h00;
              key_state_reg <= AUTH_EN ? ir_pkg::KEY_AUTH
                                       : ir_pkg::KEY_FIRE;
            end
            else
            begin
              key_cnt_reg <= key_cnt_reg + 6'h01;
            end
          end
        end
        ir_pkg::KEY_AUTH:
        begin
          if (tb.tick16_rise)
          begin
            if (key_cnt_reg == 6'(ir_pkg::AUTH_TICKS - 1))
            begin
              key_state_reg <= ir_pkg::KEY_FIRE;
            end
            else
            begin
              key_cnt_reg <= key_cnt_reg + 6'h01;
            end
          end
        end
        ir_pkg::KEY_FIRE:
        begin
          key_fire_reg <= 1'b1;
        end
        default:
        begin
          key_state_reg <= ir_pkg::KEY_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset latch
  logic reset_latch_reg;
  logic cause_pin_reg;
  logic cause_key_reg;
  logic any_src;

  assign any_src = pin_qual_reg | key_fire_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reset_latch_reg <= 1'b1;
    end
    else if (any_src)
    begin
      reset_latch_reg <= 1'b1;
    end
    else if (tb.tick16_hi)
    begin
      reset_latch_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cause_pin_reg <= 1'b0;
      cause_key_reg <= 1'b0;
    end
    else if (any_src && !reset_latch_reg)
    begin
      cause_pin_reg <= pin_qual_reg;
      cause_key_reg <= key_fire_reg;
    end
    else
    begin
      cause_pin_reg <= cause_pin_reg | pin_qual_reg;
      cause_key_reg <= cause_key_reg | key_fire_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cpu reset state
  logic wide_set_reg;
  logic nib_set_reg;
  logic ext_flag_reg;
  logic int_flag_reg;
  logic int_open_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wide_set_reg <= 1'b0;
      nib_set_reg  <= 1'b0;
    end
    else if (reset_latch_reg)
    begin
      wide_set_reg <= 1'b0;
      nib_set_reg  <= 1'b0;
    end
    else if (wide_stack_pointer_wr && nibble_stack_pointer_wr)
    begin
      wide_set_reg <= 1'b1;
      nib_set_reg  <= 1'b1;
    end
    else if (wide_stack_pointer_wr)
    begin
      wide_set_reg <= 1'b1;
      nib_set_reg  <= nib_set_reg & ~wide_set_reg;
    end
    else if (nibble_stack_pointer_wr)
    begin
      nib_set_reg  <= 1'b1;
      wide_set_reg <= wide_set_reg & ~nib_set_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_open_reg <= 1'b0;
    end
    else
    begin
      int_open_reg <= wide_set_reg & nib_set_reg & ~reset_latch_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_flag_reg <= 1'b0;
    end
    else if (reset_latch_reg)
    begin
      ext_flag_reg <= 1'b0;
    end
    else if (extension_register_wr)
    begin
      ext_flag_reg <= 1'b1;
    end
    else if (instr_done)
    begin
      ext_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_flag_reg <= 1'b0;
    end
    else if (reset_latch_reg)
    begin
      int_flag_reg <= 1'b0;
    end
    else if (int_flag_wr)
    begin
      int_flag_reg <= int_flag_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state
  logic [NPORT-1:0] port_dir_reg;
  logic             pready_reg;
  logic [31:0]      prdata_reg;
  logic             pslverr_reg;
  logic             acc;
  logic             hit;
  logic [31:0]      rd_next;
  logic [7:0]       status;

  assign acc    = psel & penable & ~pready_reg;
  assign status = {cause_key_reg, cause_pin_reg, int_flag_reg, ext_flag_reg,
                   int_open_reg, nib_set_reg, wide_set_reg, reset_latch_reg};

  always_comb
  begin
    hit     = 1'b1;
    rd_next = 32'h00000000;
    case (paddr)
      ir_pkg::OFS_PORT_DIR: rd_next[NPORT-1:0] = port_dir_reg;
      ir_pkg::OFS_STATUS:   rd_next[7:0]       = status;
      ir_pkg::OFS_START_PC: rd_next[15:0]      = ir_pkg::START_PC;
      default:              hit                = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= acc;
      pslverr_reg <= acc & ~hit;
      prdata_reg  <= (acc && !pwrite) ? rd_next : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_dir_reg <= '0;
    end
    else if (reset_latch_reg)
    begin
      port_dir_reg <= '0;
    end
    else if (acc && pwrite && paddr == ir_pkg::OFS_PORT_DIR)
    begin
      port_dir_reg <= pwdata[NPORT-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  logic [NPORT-1:0] port_oe_reg;
  logic [NPORT-1:0] port_pd_reg;
  logic             rst_pd_reg;
  logic [15:0]      pc_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_oe_reg <= '0;
      port_pd_reg <= '0;
      rst_pd_reg  <= 1'b0;
      pc_reg      <= 16'h0000;
    end
    else
    begin
      port_oe_reg <= reset_latch_reg ? '0 : port_dir_reg;
      port_pd_reg <= PORT_PULLDOWN[NPORT-1:0] & ~port_dir_reg;
      rst_pd_reg  <= RST_PULLDOWN;
      pc_reg      <= ir_pkg::START_PC;
    end
  end

  assign pready                = pready_reg;
  assign prdata                = prdata_reg;
  assign pslverr               = pslverr_reg;
  assign init_reset            = reset_latch_reg;
  assign program_counter_start = pc_reg;
  assign int_flag              = int_flag_reg;
  assign ext_flag              = ext_flag_reg;
  assign int_open              = int_open_reg;
  assign reset_pin_pulldown_en = rst_pd_reg;
  assign port_oe               = port_oe_reg;
  assign port_pulldown_en      = port_pd_reg;

endmodule

/* File: ir_init_reset_chk.sv */
// Purpose: concurrent checks on the initial reset block ports
// Assumes: oscillator period of OSC_CYC pclk cycles, no authorizer
// Notes:   bound to every ir_init_reset instance
`timescale 1ns/1ps
module ir_chk
#(
  parameter logic [2:0]  KEY_COMBO    = 3'h1,
  parameter bit          RST_PULLDOWN = 1'b1,
  parameter int unsigned NPORT        = 24,
  parameter int unsigned OSC_CYC      = 4
)
(
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pready,
  input wire logic             reset_pin,
  input wire logic [3:0]       key_input_ports,
  input wire logic             extension_register_wr,
  input wire logic             wide_stack_pointer_wr,
  input wire logic             init_reset,
  input wire logic [15:0]      program_counter_start,
  input wire logic             int_flag,
  input wire logic             ext_flag,
  input wire logic             int_open,
  input wire logic             reset_pin_pulldown_en,
  input wire logic [NPORT-1:0] port_oe
);
  localparam int unsigned REL_MAX = 1026 * OSC_CYC + 16;
  localparam logic [3:0] MASK = (KEY_COMBO == 3'h2) ? 4'h3 :
                                (KEY_COMBO == 3'h3) ? 4'h7 :
                                (KEY_COMBO == 3'h4) ? 4'hF : 4'h0;
  logic        key_full;
  logic [7:0]  pin_cnt;
  logic [7:0]  key_cnt;
  logic [15:0] rel_cnt;

  assign key_full = (MASK != 4'h0) && ((key_input_ports & MASK) == MASK);

  ////////////////////////////////////////////////////////////////////////////
  // run lengths of each source and of a pending release
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) pin_cnt <= 8'h00;
    else if (!reset_pin) pin_cnt <= 8'h00;
    else if (pin_cnt != 8'hFF) pin_cnt <= pin_cnt + 8'h01;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) key_cnt <= 8'h00;
    else if (!key_full) key_cnt <= 8'h00;
    else if (key_cnt != 8'hFF) key_cnt <= key_cnt + 8'h01;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) rel_cnt <= 16'h0000;
    else if (!init_reset || reset_pin || key_full) rel_cnt <= 16'h0000;
    else rel_cnt <= rel_cnt + 16'h0001;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // source runs are judged one sample back: qualify, then latch
  a_pin_assert: assert property (
    pin_cnt >= 8'h18 |-> init_reset)
    else $error("reset pin held high without internal reset");
  a_noise_reject: assert property ($rose(init_reset) |->
    ($past(pin_cnt) >= 8'h14) || ($past(key_cnt) >= 8'h96))
    else $error("internal reset from a too short source pulse");
  a_release_idle: assert property ($fell(init_reset) |->
    ($past(pin_cnt) < 8'h14) && ($past(key_cnt) < 8'hC8))
    else $error("internal reset released with a source active");
  a_release_bound: assert property (rel_cnt <= REL_MAX)
    else $error("internal reset release took too long");
  a_start_addr: assert property (!init_reset |->
    program_counter_start == ir_pkg::START_PC)
    else $error("start address wrong after reset");
  a_flags_clear: assert property (init_reset |=>
    !int_flag && !ext_flag && !int_open)
    else $error("cpu flags not cleared in reset");
  a_ext_set: assert property (extension_register_wr && !init_reset |=>
    ext_flag)
    else $error("extension flag not set by write");
  a_int_reblock: assert property (wide_stack_pointer_wr && int_open &&
    !init_reset |-> ##[1:2] !int_open)
    else $error("interrupts stay open after pointer rewrite");
  a_pins_input: assert property (init_reset |=> port_oe == '0)
    else $error("shared pins driven during reset");
  a_pin_pull: assert property (!init_reset |->
    reset_pin_pulldown_en == RST_PULLDOWN)
    else $error("reset pin pull-down option wrong");
  a_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");

  c_reset: cover property ($rose(init_reset));
  c_open: cover property ($rose(int_open));
  c_keys: cover property (key_full && key_cnt == 8'd150);
endmodule

bind ir_init_reset ir_chk
#(
  .KEY_COMBO    (KEY_COMBO),
  .RST_PULLDOWN (RST_PULLDOWN),
  .NPORT        (NPORT)
) ir_chk_inst
(
  .pclk                  (pclk),
  .presetn               (presetn),
  .psel                  (psel),
  .penable               (penable),
  .pready                (pready),
  .reset_pin             (reset_pin),
  .key_input_ports       (key_input_ports),
  .extension_register_wr (extension_register_wr),
  .wide_stack_pointer_wr (wide_stack_pointer_wr),
  .init_reset            (init_reset),
  .program_counter_start (program_counter_start),
  .int_flag              (int_flag),
  .ext_flag              (ext_flag),
  .int_open              (int_open),
  .reset_pin_pulldown_en (reset_pin_pulldown_en),
  .port_oe               (port_oe)
);

/* File: ir_ext_drv.sv */
// Purpose: external reset driver, key switches and oscillator
// Assumes: oscillator runs free at a quarter of pclk
// Notes:   released pin and keys read low through their pull-downs
`timescale 1ns/1ps
module ir_ext_drv
(
  input  wire logic  pclk,
  output logic       reset_pin,
  output logic [3:0] key_input_ports,
  output logic       low_speed_oscillator
);
  logic osc_div;

  // pin high from power-on, keys idle low until pressed
  initial
  begin
    reset_pin = 1'b1;
    key_input_ports = 4'h0;
    low_speed_oscillator = 1'b0;
    osc_div = 1'b0;
  end

  always @(posedge pclk)
  begin
    osc_div <= ~osc_div;
    if (osc_div) low_speed_oscillator <= ~low_speed_oscillator;
  end

  // caller chooses length; real resets hold 0.1 us or longer
  task pin_hold(input int n);
    reset_pin <= 1'b1;
    repeat (n) @(posedge pclk);
    reset_pin <= 1'b0;
  endtask

  // keys pressed only while the oscillator runs
  task keys_hold(input logic [3:0] k, input int n);
    key_input_ports <= k;
    repeat (n) @(posedge pclk);
    key_input_ports <= 4'h0;
  endtask
endmodule

/* File: initial_reset_logic_bench.sv */
// Purpose: self-checking bench of the initial reset block
// Assumes: three-key combination, no hold-time authorizer
// Notes:   fast oscillator keeps the 16 Hz tick short
`timescale 1ns/1ps
module initial_reset_logic_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        wide_wr, nib_wr, ext_wr, done, iwr, reset_pin, osc;
  logic        init_reset, int_flag, ext_flag, int_open, rpd;
  logic [3:0]  keys, k;
  logic [7:0]  paddr;
  logic [15:0] pc;
  logic [23:0] port_oe, port_pd, dir;
  logic [31:0] pwdata, prdata, rd;
  int          n_fail, compares, seed, n;

  ir_ext_drv drv_inst (.pclk(pclk), .reset_pin(reset_pin),
    .key_input_ports(keys), .low_speed_oscillator(osc));

  ir_init_reset #(.KEY_COMBO(ir_pkg::KEY_OPT_THREE)) ir_init_reset_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .reset_pin(reset_pin),
    .key_input_ports(keys), .low_speed_oscillator(osc),
    .wide_stack_pointer_wr(wide_wr), .nibble_stack_pointer_wr(nib_wr),
    .extension_register_wr(ext_wr), .instr_done(done),
    .int_flag_wr(iwr), .int_flag_val(1'b1), .init_reset(init_reset),
    .program_counter_start(pc), .int_flag(int_flag), .ext_flag(ext_flag),
    .int_open(int_open), .reset_pin_pulldown_en(rpd), .port_oe(port_oe),
    .port_pulldown_en(port_pd));

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge pclk);
      t++;
    end
    while (pready !== 1'b1 && t < 50);
    if (pready !== 1'b1)
      n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task cpu(input logic [4:0] v);
    {iwr, done, ext_wr, nib_wr, wide_wr} <= v;
    @(posedge pclk);
    {iwr, done, ext_wr, nib_wr, wide_wr} <= 5'h00;
    repeat (3) @(posedge pclk);
  endtask

  task wait_rel;
    n = 0;
    while (init_reset !== 1'b0 && n < 70000)
    begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, n < 4130}, 32'h00000001);
  endtask

  function logic key_exp(input logic [3:0] kv);
    return (kv & 4'h7) == 4'h7;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 44;
    n_fail = 0;
    compares = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {iwr, done, ext_wr, nib_wr, wide_wr} = 5'h00;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    drv_inst.pin_hold(400);
    wait_rel;
    chk({16'h0, pc}, 32'h00000110);
    chk({29'h0, int_flag, ext_flag, int_open}, 32'h0);
    chk({31'h0, rpd}, 32'h00000001);
    chk({8'h0, port_oe}, 32'h0);
    chk({8'h0, port_pd}, 32'h00FFFFFF);
    $display("test power_up done");
    apb(1'b0, ir_pkg::OFS_START_PC, 32'h0);
    chk(rd, 32'h00000110);
    apb(1'b0, ir_pkg::OFS_STATUS, 32'h0);
    chk(rd & 32'h000000FF, 32'h00000040);
    for (int i = 0; i < 3; i++)
    begin
      dir = 24'($random(seed));
      apb(1'b1, ir_pkg::OFS_PORT_DIR, {8'h0, dir});
      apb(1'b0, ir_pkg::OFS_PORT_DIR, 32'h0);
      chk(rd, {8'h0, dir});
      chk({8'h0, port_oe}, {8'h0, dir});
      chk({8'h0, port_pd}, {8'h0, ~dir});
    end
    apb(1'b0, 8'h0C, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    $display("test registers done");
    for (int i = 0; i < 4; i++)
    begin
      cpu(i[0] ? 5'h02 : 5'h01);
      chk({31'h0, int_open}, {31'h0, i[0]});
    end
    cpu(5'h04);
    chk({31'h0, ext_flag}, 32'h1);
    cpu(5'h08);
    chk({31'h0, ext_flag}, 32'h0);
    cpu(5'h14);
    chk({30'h0, int_flag, ext_flag}, 32'h3);
    $display("test cpu done");
    drv_inst.pin_hold(19);
    repeat (10) @(posedge pclk);
    chk({31'h0, init_reset}, 32'h0);
    drv_inst.pin_hold(20000);
    chk({31'h0, init_reset}, 32'h1);
    wait_rel;
    chk({29'h0, int_flag, ext_flag, int_open}, 32'h0);
    chk({8'h0, port_oe}, 32'h0);
    $display("test reset_pin done");
    drv_inst.keys_hold(4'h7, 120);
    chk({31'h0, init_reset}, 32'h0);
    // let the keys fall before the next press
    repeat (5) @(posedge pclk);
    for (int i = 0; i < 9; i++)
    begin
      k = (i == 0) ? 4'h7 : (i == 1) ? 4'hF : (i == 2) ? 4'h6 :
          4'($random(seed));
      drv_inst.keys_hold(k, 260);
      chk({31'h0, init_reset}, {31'h0, key_exp(k)});
      if (key_exp(k))
        wait_rel;
      else
        repeat (5) @(posedge pclk);
    end
    $display("test keys done");
    report_and_stop;
  end

  initial
  begin
    repeat (90000) @(posedge pclk);
    n_fail++;
    report_and_stop;
  end
endmodule
